//--- shared/ssc_params.svh
// Constants of the sequence step controller: offsets, resets, field limits, timing
`ifndef SSC_PARAMS_SVH
`define SSC_PARAMS_SVH

`define SSC_CLK_MHZ 250
`define SSC_TICK_US 1000
`define SSC_TICK_CYCLES (`SSC_TICK_US * `SSC_CLK_MHZ)
`define SSC_SLOW_HALF_TICKS 500
`define SSC_FAST_HALF_TICKS 125

`define SSC_FIRST_LOC 8'h0B
`define SSC_LAST_LOC 8'hFF

`define SSC_ADDR_START 3'h0
`define SSC_ADDR_STOP 3'h1
`define SSC_ADDR_REPEAT 3'h2
`define SSC_ADDR_DEFDWELL 3'h3
`define SSC_ADDR_STATUS 3'h4
`define SSC_ADDR_RREP 3'h5

`define SSC_RST_START 8'h0B
`define SSC_RST_STOP 8'hFF
`define SSC_RST_REPEAT 8'h01
`define SSC_RST_DEFDWELL 16'h03E8

`define SSC_STATUS_STEP_BIT 10
`define SSC_STATUS_STATE_LSB 8

`define SSC_N_BASE 4'h5
`define SSC_N_EXT 4'hB
`define SSC_RO_LOCATION 4'h5
`define SSC_RO_RREP 4'h6
`define SSC_RO_USET 4'h7
`define SSC_RO_ISET 4'h8
`define SSC_RO_DWELL 4'h9
`define SSC_RO_SSET 4'hA

`endif

//--- shared/ssc_pkg.sv
// Types shared by the sequence step controller files
package ssc_pkg;
  typedef enum logic [1:0] {
    SEQ_READY = 2'b00,
    SEQ_RUNNING = 2'b01,
    SEQ_SUSPENDED = 2'b10
  } seq_state_type;
endpackage

//--- hdl/seq_indicator_blink.sv
// Blink generator for the sequence indicator
`include "ssc_params.svh"
module seq_indicator_blink #(
  parameter logic [9:0] SLOW_HALF = 10'(`SSC_SLOW_HALF_TICKS),
  parameter logic [9:0] FAST_HALF = 10'(`SSC_FAST_HALF_TICKS)
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_tick,
  input wire ssc_pkg::seq_state_type i_state,
  output logic o_indicator
);
  logic [9:0] cnt_reg, cnt_next;
  logic led_reg, led_next;
  logic [9:0] half;

  always_comb begin
    half = (i_state == ssc_pkg::SEQ_SUSPENDED) ? SLOW_HALF : FAST_HALF;
    cnt_next = cnt_reg;
    led_next = led_reg;
    if (i_state == ssc_pkg::SEQ_READY) begin
      cnt_next = 10'h000;
      led_next = 1'b0;
    end else if (i_tick) begin
      if (cnt_reg + 10'h001 >= half) begin
        cnt_next = 10'h000;
        led_next = ~led_reg;
      end else begin
        cnt_next = cnt_reg + 10'h001;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      cnt_reg <= 10'h000;
      led_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      led_reg <= led_next;
    end
  end

  assign o_indicator = led_reg;
endmodule

//--- hdl/readout_select.sv
// Readout-select key handling: remembers the last parameter, steps through the list
`include "ssc_params.svh"
module readout_select (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_select_key,
  input wire logic i_exit,
  input wire logic i_ext_en,
  output logic o_open,
  output logic [3:0] o_index
);
  logic open_reg, open_next;
  logic [3:0] idx_reg, idx_next;
  logic [3:0] count;

  always_comb begin
    count = i_ext_en ? `SSC_N_EXT : `SSC_N_BASE;
    open_next = open_reg;
    idx_next = idx_reg;
    // Extended entries vanish when the sequence ends
    if (!i_ext_en && idx_reg >= `SSC_N_BASE) begin
      idx_next = 4'h0;
    end
    if (i_exit) begin
      open_next = 1'b0;
    end else if (i_select_key) begin
      if (!open_reg) begin
        open_next = 1'b1;
      end else if (idx_reg + 4'h1 >= count) begin
        idx_next = 4'h0;
      end else begin
        idx_next = idx_reg + 4'h1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      open_reg <= 1'b0;
      idx_reg <= 4'h0;
    end else begin
      open_reg <= open_next;
      idx_reg <= idx_next;
    end
  end

  assign o_open = open_reg;
  assign o_index = idx_reg;
endmodule

//--- hdl/sequence_step_control.sv
// Sequence controller: run, hold, single step and jump to first location
//
// Local design decisions: the placing of the registers and the plain strobed port.
`include "ssc_params.svh"
module sequence_step_control #(
  parameter int TICK_CYCLES = `SSC_TICK_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [2:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  input wire logic i_advance_one_location_cmd,
  input wire logic i_jump_to_first_cmd,
  input wire logic i_restart_cmd,
  input wire logic i_hold_cmd,
  input wire logic i_resume_cmd,
  input wire logic i_end_cmd,
  input wire logic i_output_toggle,
  input wire logic i_select_key,
  input wire logic i_readout_exit,
  input wire logic [15:0] i_meas_value,
  output logic [7:0] o_mem_addr,
  output logic o_mem_rd,
  input wire logic [15:0] i_mem_uset,
  input wire logic [15:0] i_mem_iset,
  input wire logic [15:0] i_mem_tset,
  input wire logic i_mem_tset_valid,
  input wire logic i_mem_sset,
  output logic [15:0] o_uset,
  output logic [15:0] o_iset,
  output logic o_sset,
  output logic o_output_on,
  output logic [7:0] o_location,
  output logic [7:0] o_rrep,
  output logic [1:0] o_state,
  output logic o_step_mode,
  output logic o_sequence_indicator,
  output logic o_ext_list,
  output logic o_readout_open,
  output logic [3:0] o_readout_index,
  output logic [15:0] o_readout_value
);
  // Configuration registers
  logic [7:0] start_reg, start_next;
  logic [7:0] stop_reg, stop_next;
  logic [7:0] repeat_reg, repeat_next;
  logic [15:0] defdwell_reg, defdwell_next;
  logic [15:0] rdata_reg, rdata_next;
  logic [7:0] wr_loc;

  // Sequencer state
  ssc_pkg::seq_state_type state_reg, state_next;
  logic step_reg, step_next;
  logic [7:0] loc_reg, loc_next;
  logic [7:0] rrep_reg, rrep_next;
  logic out_on_reg, out_on_next;
  logic pend_reg, pend_next;
  logic rd_reg, rd_next;
  logic [15:0] dwell_cnt_reg, dwell_cnt_next;
  logic [15:0] dwell_reg, dwell_next;
  logic [15:0] uset_reg, uset_next;
  logic [15:0] iset_reg, iset_next;
  logic sset_reg, sset_next;
  logic [7:0] wrap_loc;
  logic ext_reg, ext_next;

  // Tick timebase for dwell and blink
  logic [31:0] tick_cnt_reg, tick_cnt_next;
  logic tick_reg, tick_next;

  // Readout value
  logic [15:0] ro_value_reg, ro_value_next;
  logic ro_open;
  logic [3:0] ro_index;

  // Register port
  always_comb begin
    start_next = start_reg;
    stop_next = stop_reg;
    repeat_next = repeat_reg;
    defdwell_next = defdwell_reg;
    rdata_next = 16'h0000;
    // Below the first sequence location is setup memory, so clamp up
    wr_loc = (i_wdata[7:0] < `SSC_FIRST_LOC) ? `SSC_FIRST_LOC : i_wdata[7:0];
    if (i_wr) begin
      case (i_addr)
        `SSC_ADDR_START: start_next = wr_loc;
        `SSC_ADDR_STOP: stop_next = wr_loc;
        `SSC_ADDR_REPEAT: repeat_next = i_wdata[7:0];
        `SSC_ADDR_DEFDWELL: defdwell_next = i_wdata;
        default: ;
      endcase
    end
    if (i_rd) begin
      case (i_addr)
        `SSC_ADDR_START: rdata_next = {8'h00, start_reg};
        `SSC_ADDR_STOP: rdata_next = {8'h00, stop_reg};
        `SSC_ADDR_REPEAT: rdata_next = {8'h00, repeat_reg};
        `SSC_ADDR_DEFDWELL: rdata_next = defdwell_reg;
        `SSC_ADDR_STATUS: begin
          rdata_next = {8'h00, loc_reg};
          rdata_next[`SSC_STATUS_STATE_LSB +: 2] = state_reg;
          rdata_next[`SSC_STATUS_STEP_BIT] = step_reg;
        end
        `SSC_ADDR_RREP: rdata_next = {8'h00, rrep_reg};
        default: rdata_next = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      start_reg <= `SSC_RST_START;
      stop_reg <= `SSC_RST_STOP;
      repeat_reg <= `SSC_RST_REPEAT;
      defdwell_reg <= `SSC_RST_DEFDWELL;
      rdata_reg <= 16'h0000;
    end else begin
      start_reg <= start_next;
      stop_reg <= stop_next;
      repeat_reg <= repeat_next;
      defdwell_reg <= defdwell_next;
      rdata_reg <= rdata_next;
    end
  end

  // Tick timebase
  always_comb begin
    tick_next = 1'b0;
    tick_cnt_next = tick_cnt_reg + 32'h00000001;
    if (tick_cnt_reg >= 32'(TICK_CYCLES - 1)) begin
      tick_cnt_next = 32'h00000000;
      tick_next = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      tick_cnt_reg <= 32'h00000000;
      tick_reg <= 1'b0;
    end else begin
      tick_cnt_reg <= tick_cnt_next;
      tick_reg <= tick_next;
    end
  end

  // Sequencer
  always_comb begin
    state_next = state_reg;
    step_next = step_reg;
    loc_next = loc_reg;
    rrep_next = rrep_reg;
    out_on_next = out_on_reg;
    pend_next = 1'b0;
    rd_next = 1'b0;
    dwell_cnt_next = dwell_cnt_reg;
    dwell_next = dwell_reg;
    uset_next = uset_reg;
    iset_next = iset_reg;
    sset_next = sset_reg;
    // The end address, and the top of memory, wrap back to the start
    wrap_loc = (loc_reg == stop_reg || loc_reg == `SSC_LAST_LOC) ? start_reg
               : loc_reg + 8'h01;
    if (i_output_toggle) begin
      out_on_next = ~out_on_reg;
    end
    case (state_reg)
      ssc_pkg::SEQ_READY,
      ssc_pkg::SEQ_RUNNING,
      ssc_pkg::SEQ_SUSPENDED: begin
        if (i_restart_cmd) begin
          loc_next = start_reg;
          rrep_next = repeat_reg;
          state_next = ssc_pkg::SEQ_RUNNING;
          out_on_next = 1'b1;
          rd_next = 1'b1;
        end else if (i_end_cmd && ext_reg) begin
          state_next = ssc_pkg::SEQ_READY;
          step_next = 1'b0;
        end else if (i_jump_to_first_cmd && ext_reg) begin
          loc_next = start_reg;
          state_next = ssc_pkg::SEQ_SUSPENDED;
          step_next = 1'b1;
          out_on_next = 1'b1;
          rrep_next = repeat_reg;
          rd_next = 1'b1;
        end else if (i_advance_one_location_cmd
                     && state_reg == ssc_pkg::SEQ_SUSPENDED) begin
          out_on_next = out_on_reg;
          loc_next = wrap_loc;
          step_next = 1'b1;
          rd_next = 1'b1;
        end else if (i_hold_cmd && state_reg == ssc_pkg::SEQ_RUNNING) begin
          state_next = ssc_pkg::SEQ_SUSPENDED;
        end else if ((i_resume_cmd && state_reg == ssc_pkg::SEQ_SUSPENDED)
                     || (state_reg == ssc_pkg::SEQ_RUNNING && !pend_reg
                         && tick_reg && dwell_cnt_reg + 16'h0001 >= dwell_reg)) begin
          // Resume or timed advance; a pass through the end address uses a repetition
          state_next = ssc_pkg::SEQ_RUNNING;
          rd_next = 1'b1;
          loc_next = wrap_loc;
          if (loc_reg == stop_reg) begin
            if (rrep_reg <= 8'h01) begin
              state_next = ssc_pkg::SEQ_READY;
              step_next = 1'b0;
              rd_next = 1'b0;
              loc_next = loc_reg;
              rrep_next = 8'h00;
            end else begin
              rrep_next = rrep_reg - 8'h01;
            end
          end
        end else if (state_reg == ssc_pkg::SEQ_RUNNING && tick_reg) begin
          dwell_cnt_next = dwell_cnt_reg + 16'h0001;
        end
      end
      default: begin
        state_next = ssc_pkg::SEQ_READY;
        step_next = 1'b0;
      end
    endcase
    // Dwell timer restarts on every load, so neither neighbour's time counts
    if (rd_next) begin
      dwell_cnt_next = 16'h0000;
      pend_next = 1'b1;
    end
    // Memory answers in the same cycle as the read strobe
    if (pend_reg) begin
      uset_next = i_mem_uset;
      iset_next = i_mem_iset;
      sset_next = i_mem_sset;
      dwell_next = i_mem_tset_valid ? i_mem_tset : defdwell_reg;
    end
    ext_next = (state_next != ssc_pkg::SEQ_READY);
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state_reg <= ssc_pkg::SEQ_READY;
      step_reg <= 1'b0;
      loc_reg <= `SSC_FIRST_LOC;
      rrep_reg <= 8'h00;
      out_on_reg <= 1'b0;
      pend_reg <= 1'b0;
      rd_reg <= 1'b0;
      dwell_cnt_reg <= 16'h0000;
      dwell_reg <= `SSC_RST_DEFDWELL;
      uset_reg <= 16'h0000;
      iset_reg <= 16'h0000;
      sset_reg <= 1'b0;
      ext_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      step_reg <= step_next;
      loc_reg <= loc_next;
      rrep_reg <= rrep_next;
      out_on_reg <= out_on_next;
      pend_reg <= pend_next;
      rd_reg <= rd_next;
      dwell_cnt_reg <= dwell_cnt_next;
      dwell_reg <= dwell_next;
      uset_reg <= uset_next;
      iset_reg <= iset_next;
      sset_reg <= sset_next;
      ext_reg <= ext_next;
    end
  end

  // Readout value follows the selected entry
  always_comb begin
    case (ro_index)
      `SSC_RO_LOCATION: ro_value_next = {8'h00, loc_reg};
      `SSC_RO_RREP: ro_value_next = {8'h00, rrep_reg};
      `SSC_RO_USET: ro_value_next = uset_reg;
      `SSC_RO_ISET: ro_value_next = iset_reg;
      `SSC_RO_DWELL: ro_value_next = dwell_reg;
      `SSC_RO_SSET: ro_value_next = {15'h0000, sset_reg};
      default: ro_value_next = i_meas_value;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ro_value_reg <= 16'h0000;
    end else begin
      ro_value_reg <= ro_value_next;
    end
  end

  seq_indicator_blink u_blink (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_tick(tick_reg),
    .i_state(state_reg),
    .o_indicator(o_sequence_indicator)
  );

  readout_select u_readout (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_select_key(i_select_key),
    .i_exit(i_readout_exit),
    .i_ext_en(state_reg != ssc_pkg::SEQ_READY),
    .o_open(ro_open),
    .o_index(ro_index)
  );

  assign o_rdata = rdata_reg;
  assign o_mem_addr = loc_reg;
  assign o_mem_rd = rd_reg;
  assign o_uset = uset_reg;
  assign o_iset = iset_reg;
  assign o_sset = sset_reg;
  assign o_output_on = out_on_reg;
  assign o_location = loc_reg;
  assign o_rrep = rrep_reg;
  assign o_state = state_reg;
  assign o_step_mode = step_reg;
  assign o_ext_list = ext_reg;
  assign o_readout_open = ro_open;
  assign o_readout_index = ro_index;
  assign o_readout_value = ro_value_reg;
endmodule

//--- verif/seq_mem_model.sv
// Sequence memory model that answers the controller's location reads
module seq_mem_model (
  input wire logic [7:0] i_addr,
  input wire logic i_rd,
  output logic [15:0] o_uset,
  output logic [15:0] o_iset,
  output logic [15:0] o_tset,
  output logic o_tset_valid,
  output logic o_sset
);
  timeunit 1ns;
  timeprecision 1ps;
  // Outside a read the bus shows the inverse, so a late capture loads wrong values
  assign o_uset = i_rd ? {8'hA5, i_addr} : ~{8'hA5, i_addr};
  assign o_iset = i_rd ? {8'h5A, i_addr} : ~{8'h5A, i_addr};
  assign o_tset = i_rd ? 16'h0100 : 16'hFEFF;
  assign o_tset_valid = i_rd ? i_addr[0] : ~i_addr[0];
  assign o_sset = i_rd ? i_addr[1] : ~i_addr[1];
endmodule

//--- verif/sequence_step_control_asserts.sv
// Concurrent checks on the sequence step controller ports
`include "ssc_params.svh"
module sequence_step_control_asserts (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic [2:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_advance_one_location_cmd,
  input wire logic i_jump_to_first_cmd,
  input wire logic i_restart_cmd,
  input wire logic i_resume_cmd,
  input wire logic i_end_cmd,
  input wire logic i_output_toggle,
  input wire logic i_select_key,
  input wire logic i_readout_exit,
  input wire logic [15:0] i_mem_uset,
  input wire logic [15:0] i_mem_iset,
  input wire logic i_mem_sset,
  input wire logic [7:0] o_mem_addr,
  input wire logic o_mem_rd,
  input wire logic [15:0] o_uset,
  input wire logic [15:0] o_iset,
  input wire logic o_sset,
  input wire logic o_output_on,
  input wire logic [7:0] o_location,
  input wire logic [7:0] o_rrep,
  input wire logic [1:0] o_state,
  input wire logic o_step_mode,
  input wire logic o_sequence_indicator,
  input wire logic o_ext_list,
  input wire logic o_readout_open,
  input wire logic [3:0] o_readout_index
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [1:0] SUSP = ssc_pkg::SEQ_SUSPENDED;
  localparam logic [1:0] RDY = ssc_pkg::SEQ_READY;
  logic [7:0] start_reg, stop_reg, rep_reg, next_loc;
  logic step_ok, jump_ok, quiet;
  // Shadow copies of the range registers, so wrap targets follow software writes
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      start_reg <= `SSC_RST_START;
      stop_reg <= `SSC_RST_STOP;
      rep_reg <= `SSC_RST_REPEAT;
    end else if (i_wr && i_addr == `SSC_ADDR_START) begin
      start_reg <= (i_wdata[7:0] < `SSC_FIRST_LOC) ? `SSC_FIRST_LOC : i_wdata[7:0];
    end else if (i_wr && i_addr == `SSC_ADDR_STOP) begin
      stop_reg <= (i_wdata[7:0] < `SSC_FIRST_LOC) ? `SSC_FIRST_LOC : i_wdata[7:0];
    end else if (i_wr && i_addr == `SSC_ADDR_REPEAT) begin
      rep_reg <= i_wdata[7:0];
    end
  end
  assign next_loc = (o_location == stop_reg || o_location == `SSC_LAST_LOC) ? start_reg
    : o_location + 8'h01;
  assign step_ok = o_state == SUSP && i_advance_one_location_cmd && !i_restart_cmd
    && !i_end_cmd && !i_jump_to_first_cmd;
  assign jump_ok = o_state != RDY && i_jump_to_first_cmd && !i_restart_cmd && !i_end_cmd;
  assign quiet = !(i_advance_one_location_cmd || i_jump_to_first_cmd || i_restart_cmd
    || i_end_cmd || i_resume_cmd);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  sequence s_step_done;
    o_location == $past(next_loc) && o_state == SUSP && o_step_mode;
  endsequence
  sequence s_capture;
    o_uset == $past(i_mem_uset) && o_iset == $past(i_mem_iset) && o_sset == $past(i_mem_sset);
  endsequence
  property p_step; step_ok |=> s_step_done; endproperty
  a_step: assert property (p_step) else $error("step did not reach next location");
  property p_load; (step_ok || jump_ok) |=> (o_mem_rd && o_mem_addr == o_location) ##1 s_capture;
  endproperty
  a_load: assert property (p_load) else $error("setpoints not loaded");
  property p_keep; (step_ok && !i_output_toggle) |=> $stable(o_output_on) && $stable(o_rrep);
  endproperty
  a_keep: assert property (p_keep) else $error("step changed output or rrep");
  property p_no_timed; (o_state == SUSP && quiet) |=> $stable(o_location); endproperty
  a_no_timed: assert property (p_no_timed) else $error("timed advance while held");
  property p_jump;
    jump_ok |=> o_location == $past(start_reg) && o_state == SUSP && o_step_mode && o_output_on;
  endproperty
  a_jump: assert property (p_jump) else $error("jump result wrong");
  property p_jump_rrep; jump_ok |=> o_rrep == $past(rep_reg); endproperty
  a_jump_rrep: assert property (p_jump_rrep) else $error("rrep not reloaded");
  property p_ext; o_ext_list == (o_state != RDY); endproperty
  a_ext: assert property (p_ext) else $error("extended list flag wrong");
  property p_dark; (o_state == RDY) [*3] |-> !o_sequence_indicator; endproperty
  a_dark: assert property (p_dark) else $error("indicator lit while ready");
  property p_range; o_location >= `SSC_FIRST_LOC; endproperty
  a_range: assert property (p_range) else $error("location below sequence range");
  property p_ro_open; (!o_readout_open && i_select_key && !i_readout_exit)
    |=> o_readout_open && $stable(o_readout_index);
  endproperty
  a_ro_open: assert property (p_ro_open) else $error("first press did not keep entry");
  property p_ro_next; (o_readout_open && i_select_key && !i_readout_exit)
    |=> o_readout_index == (($past(o_readout_index) == ($past(o_ext_list) ? 4'hA : 4'h4))
    ? 4'h0 : $past(o_readout_index) + 4'h1);
  endproperty
  a_ro_next: assert property (p_ro_next) else $error("readout did not advance");
endmodule

bind sequence_step_control sequence_step_control_asserts sequence_step_control_asserts_i (
  .i_clk, .i_reset, .i_addr, .i_wdata, .i_wr, .i_advance_one_location_cmd,
  .i_jump_to_first_cmd, .i_restart_cmd, .i_resume_cmd, .i_end_cmd, .i_output_toggle,
  .i_select_key, .i_readout_exit, .i_mem_uset, .i_mem_iset, .i_mem_sset, .o_mem_addr,
  .o_mem_rd, .o_uset, .o_iset, .o_sset, .o_output_on, .o_location, .o_rrep, .o_state,
  .o_step_mode, .o_sequence_indicator, .o_ext_list, .o_readout_open, .o_readout_index);

//--- verif/tb.sv
// Self-checking bench of the sequence step controller
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICKS = 4;
  localparam int ADV = 0, JMP = 1, RST = 2, HLD = 3, RES = 4, FIN = 5, TOG = 6, SEL = 7, EXT = 8;
  logic i_clk = 1'b0, i_reset = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
  logic [2:0] i_addr = 3'h0;
  logic [15:0] i_wdata = 16'h0000, i_meas_value = 16'h0000, meas;
  logic [8:0] cmd = 9'h000;
  logic [15:0] o_rdata, o_uset, o_iset, o_readout_value, i_mem_uset, i_mem_iset, i_mem_tset;
  logic [7:0] o_mem_addr, o_location, o_rrep, loc;
  logic [1:0] o_state;
  logic [3:0] o_readout_index;
  logic o_mem_rd, o_sset, o_output_on, o_step_mode, o_sequence_indicator, o_ext_list;
  logic o_readout_open, i_mem_tset_valid, i_mem_sset, out_was;
  logic [15:0] rst_tab [8] = '{16'h000B, 16'h00FF, 16'h0001, 16'h03E8, 16'h000B, 16'h0000,
    16'h0000, 16'h0000};
  int mismatches = 0, cmp_count = 0, cycles = 0;
  always #2 i_clk = ~i_clk;
  sequence_step_control #(.TICK_CYCLES(TICKS)) sequence_step_control_i (
    .i_clk, .i_reset, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_advance_one_location_cmd(cmd[ADV]), .i_jump_to_first_cmd(cmd[JMP]),
    .i_restart_cmd(cmd[RST]), .i_hold_cmd(cmd[HLD]), .i_resume_cmd(cmd[RES]),
    .i_end_cmd(cmd[FIN]), .i_output_toggle(cmd[TOG]), .i_select_key(cmd[SEL]),
    .i_readout_exit(cmd[EXT]), .i_meas_value, .o_mem_addr, .o_mem_rd, .i_mem_uset,
    .i_mem_iset, .i_mem_tset, .i_mem_tset_valid, .i_mem_sset, .o_uset, .o_iset, .o_sset,
    .o_output_on, .o_location, .o_rrep, .o_state, .o_step_mode, .o_sequence_indicator,
    .o_ext_list, .o_readout_open, .o_readout_index, .o_readout_value);
  seq_mem_model seq_mem_model_i (.i_addr(o_mem_addr), .i_rd(o_mem_rd), .o_uset(i_mem_uset),
    .o_iset(i_mem_iset), .o_tset(i_mem_tset), .o_tset_valid(i_mem_tset_valid),
    .o_sset(i_mem_sset));
  function automatic logic [7:0] next_of(input logic [7:0] a);
    return (a == 8'h22) ? 8'h20 : a + 8'h01;
  endfunction
  // Entries 0 to 4 are measured values fed in from outside
  function automatic logic [15:0] ro_exp(input logic [3:0] k);
    case (k)
      4'h5: return 16'h0020;
      4'h6: return 16'h0003;
      4'h7: return 16'hA520;
      4'h8: return 16'h5A20;
      4'h9: return 16'h0040;
      4'hA: return 16'h0000;
      default: return meas;
    endcase
  endfunction
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic pulse(input int k);
    @(posedge i_clk) cmd <= 9'h001 << k;
    @(posedge i_clk) cmd <= 9'h000;
    #1;
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge i_clk) {i_wr, i_addr, i_wdata} <= {1'b1, a, d};
    @(posedge i_clk) i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [15:0] exp);
    @(posedge i_clk) {i_rd, i_addr} <= {1'b1, a};
    @(posedge i_clk) i_rd <= 1'b0;
    #1 chk("rdata", exp, o_rdata);
  endtask
  task automatic half(input logic [15:0] exp);
    int n;
    logic v;
    for (int h = 0; h < 2; h++) begin
      n = 0;
      v = o_sequence_indicator;
      while (o_sequence_indicator === v && n < 3000) begin
        @(posedge i_clk);
        #1 n++;
      end
    end
    chk("blink half", exp, 16'(n));
  endtask
  task automatic jump_chk();
    pulse(JMP);
    chk("jump loc", 16'h0020, o_location);
    chk("jump state", 16'(ssc_pkg::SEQ_SUSPENDED), o_state);
    chk("jump out", 16'h0001, o_output_on);
    chk("jump rrep", 16'h0003, o_rrep);
    chk("jump mode", 16'h0001, o_step_mode);
    @(posedge i_clk);
    #1 chk("jump uset", 16'hA520, o_uset);
  endtask
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      wrap_up();
    end
  end
  initial begin
    void'($urandom(32'hFD7C));
    repeat (4) @(posedge i_clk);
    i_reset <= 1'b0;
    for (int a = 0; a < 8; a++) rd(3'(a), rst_tab[a]);
    wr(3'h0, 16'h0005);
    rd(3'h0, 16'h000B);
    wr(3'h0, 16'h0020);
    wr(3'h1, 16'h0022);
    wr(3'h2, 16'h0003);
    wr(3'h3, 16'h0040);
    wr(3'h4, 16'hFFFF);
    rd(3'h4, 16'h000B);
    pulse(RST);
    chk("ext list", 16'h0001, o_ext_list);
    repeat (24 + $urandom_range(40)) @(posedge i_clk);
    pulse(HLD);
    half(16'(500 * TICKS));
    pulse(TOG);
    out_was = o_output_on;
    for (int n = 0; n < 4 + $urandom_range(2); n++) begin
      loc = o_location;
      pulse(ADV);
      chk("step loc", 16'(next_of(loc)), o_location);
      chk("step state", 16'(ssc_pkg::SEQ_SUSPENDED), o_state);
      chk("step mode", 16'h0001, o_step_mode);
      chk("step out", 16'(out_was), o_output_on);
      chk("step rrep", 16'h0003, o_rrep);
      @(posedge i_clk);
      #1 chk("step uset", {8'hA5, next_of(loc)}, o_uset);
      chk("step iset", {8'h5A, next_of(loc)}, o_iset);
      chk("step sset", 16'(next_of(loc) >> 1) & 16'h0001, o_sset);
    end
    loc = o_location;
    repeat (600) @(posedge i_clk);
    #1 chk("held loc", 16'(loc), o_location);
    jump_chk();
    meas = 16'($urandom);
    @(posedge i_clk) i_meas_value <= meas;
    pulse(SEL);
    @(posedge i_clk);
    #1 chk("ro index", 16'h0000, o_readout_index);
    chk("ro value", meas, o_readout_value);
    for (int k = 1; k < 12; k++) begin
      if (k == 7) begin
        pulse(EXT);
        pulse(SEL);
        chk("ro kept", 16'h0006, o_readout_index);
      end
      pulse(SEL);
      @(posedge i_clk);
      #1 chk("ro index", 16'(k % 11), o_readout_index);
      chk("ro value", ro_exp(4'(k % 11)), o_readout_value);
    end
    pulse(RES);
    half(16'(125 * TICKS));
    pulse(TOG);
    // Timed run through the end address uses up one repetition
    for (int n = 0; n < 2000 && o_location !== 8'h20; n++) @(posedge i_clk) #1;
    chk("wrap loc", 16'h0020, o_location);
    chk("wrap rrep", 16'h0002, o_rrep);
    // Move on first, so the jump below has to reload location and repetitions
    repeat (300) @(posedge i_clk);
    jump_chk();
    pulse(FIN);
    chk("end state", 16'(ssc_pkg::SEQ_READY), o_state);
    chk("end mode", 16'h0000, o_step_mode);
    // A jump out of a plain run is the first entry into step-by-step control
    pulse(RST);
    jump_chk();
    wrap_up();
  end
endmodule
